// >>> core/dma_abort_suspend_bus_sizing.sv
`timescale 1ns/1ps
module dma_abort_suspend_bus_sizing
   import dma_pkg::*;
#(
   parameter int CW = COUNT_W
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // software control
   input wire logic enable_set_in,
   output logic master_transfer_enable_out,
   // channel setup
   input wire logic load_in,
   input wire logic [31:0] src_load_in,
   input wire logic [31:0] dst_load_in,
   input wire logic [CW-1:0] count_load_in,
   output logic [CW-1:0] count_out,
   // requests and system events
   input wire logic dma_req_in,
   input wire logic nmi_n_in,
   input wire logic stop_mode_in,
   input wire logic bus_hold_request_in,
   input wire logic refresh_req_in,
   // target sizing
   input wire logic src_bus16_in,
   input wire logic dst_bus16_in,
   input wire logic dst_sdram_in,
   // bus
   input wire logic [31:0] rd_data_in,
   output logic [31:0] addr_out,
   output logic [31:0] wr_data_out,
   output logic rd_out,
   output logic wr_out,
   output logic burst_out,
   output logic bus_cycle_start_n_out,
   output logic transfer_acknowledge_n_out,
   output logic transfer_end_strobe_n_out,
   output logic hold_ack_out
);
   if (CW < 2 || CW > 24) begin : g_bad_cw
      $error("dma_abort_suspend_bus_sizing: CW out of range");
   end

   typedef struct packed {
      state_t fsm;
      logic xfer_en;
      logic abort_pend;
      logic nmi_q;
      logic stop_q;
      logic last;
      logic burst;
      logic src16;
      logic dst16;
      logic [31:0] buffer;
   } core_t;

   core_t s;
   core_t next_s;
   logic advance;
   logic [31:0] src;
   logic [31:0] dst;
   logic [CW-1:0] count;
   logic nmi_act;
   logic abort_now;
   logic paused_req;
   logic go;
   logic in_write;

   dma_channel_state #(
      .AW(32),
      .CW(CW)
   ) i_dma_channel_state (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .load_in(load_in),
      .src_load_in(src_load_in),
      .dst_load_in(dst_load_in),
      .count_load_in(count_load_in),
      .advance_in(advance),
      .src_out(src),
      .dst_out(dst),
      .count_out(count)
   );

   assign nmi_act = ~nmi_n_in;
   assign paused_req = bus_hold_request_in | refresh_req_in;
   assign in_write = (s.fsm == S_WA) || (s.fsm == S_WB) || (s.fsm == S_W2);
   // only a fresh nmi edge or a stop exit acts; nothing is queued
   assign abort_now = s.xfer_en & ~stop_mode_in & nmi_act &
      (~s.nmi_q | s.stop_q);
   assign go = s.xfer_en & ~stop_mode_in & dma_req_in & ~paused_req &
      (count != '0) & ~abort_now;

   always_comb begin
      next_s = s;
      advance = 1'b0;
      next_s.nmi_q = nmi_act;
      next_s.stop_q = stop_mode_in;
      if (enable_set_in) begin
         next_s.xfer_en = 1'b1;
      end
      if (abort_now && in_write) begin
         next_s.abort_pend = 1'b1;
      end else if (abort_now) begin
         next_s.xfer_en = 1'b0;
         next_s.fsm = S_IDLE;
      end
      unique case (s.fsm)
         S_IDLE, S_PAUSE: begin
            if (s.fsm == S_PAUSE && !paused_req && !go) begin
               next_s.fsm = S_IDLE;
            end
            if (go && (s.fsm == S_IDLE || !paused_req)) begin
               next_s.fsm = S_RD1;
               next_s.src16 = src_bus16_in;
               next_s.dst16 = dst_bus16_in;
               next_s.burst = dst_bus16_in & dst_sdram_in;
               next_s.last = (count == CW'(1));
            end
         end
         S_RD1: begin
            if (!abort_now) begin
               if (s.src16) begin
                  next_s.buffer[15:0] = rd_data_in[15:0];
                  next_s.fsm = S_RD2;
               end else begin
                  next_s.buffer = rd_data_in;
                  next_s.fsm = S_WA;
               end
            end
         end
         S_RD2: begin
            if (!abort_now) begin
               next_s.buffer[31:16] = rd_data_in[15:0];
               next_s.fsm = S_WA;
            end
         end
         S_WA: begin
            next_s.fsm = S_WB;
         end
         S_WB, S_W2: begin
            if (s.fsm == S_WB && s.dst16) begin
               next_s.fsm = S_W2;
            end else begin
               advance = 1'b1;
               next_s.abort_pend = 1'b0;
               if (s.abort_pend || abort_now) begin
                  next_s.xfer_en = 1'b0;
                  next_s.fsm = S_IDLE;
               end else if (paused_req) begin
                  next_s.fsm = S_PAUSE;
               end else begin
                  next_s.fsm = S_IDLE;
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         s <= '{fsm: S_IDLE, xfer_en: ENABLE_RESET, abort_pend: 1'b0,
                nmi_q: 1'b0, stop_q: 1'b0, last: 1'b0, burst: 1'b0,
                src16: 1'b0, dst16: 1'b0, buffer: DATA_RESET};
      end else begin
         s <= next_s;
      end
   end

   // strobes decode registered state, so they change on clock edges only
   assign master_transfer_enable_out = s.xfer_en;
   assign count_out = count;
   assign rd_out = (s.fsm == S_RD1) || (s.fsm == S_RD2);
   assign wr_out = in_write;
   assign burst_out = (s.fsm == S_RD2) || (s.fsm == S_W2);
   assign bus_cycle_start_n_out = ~((s.fsm == S_RD1) || (s.fsm == S_WA));
   assign transfer_acknowledge_n_out = ~(rd_out | wr_out);
   assign hold_ack_out = (s.fsm == S_PAUSE);
   assign transfer_end_strobe_n_out = ~(s.last &&
      ((s.fsm == S_WB && !s.burst) ||
       (s.fsm == S_W2 && s.burst)));
   assign addr_out = rd_out ?
      ((s.fsm == S_RD2) ? src + HALF_STEP : src) :
      ((s.fsm == S_W2) ? dst + HALF_STEP : dst);
   assign wr_data_out = (s.fsm == S_W2) ? {16'h0000, s.buffer[31:16]} :
      (s.dst16 ? {16'h0000, s.buffer[15:0]} : s.buffer);

   sequence q_write_start;
      s.fsm == S_WA;
   endsequence
   sequence q_write_done;
      s.fsm == S_WB;
   endsequence

   property p_abort_after_write;
      @(posedge clk_in) disable iff (rst_in)
      (abort_now and q_write_start) |=> (q_write_done and s.abort_pend);
   endproperty
   a_abort_after_write: assert property (p_abort_after_write)
      else $error("abort cut a write short");

   property p_abort_clears;
      @(posedge clk_in) disable iff (rst_in)
      s.abort_pend && transfer_end_strobe_n_out == 1'b1 && advance
      |=> !s.xfer_en && s.fsm == S_IDLE;
   endproperty
   a_abort_clears: assert property (p_abort_clears)
      else $error("enable not cleared after abort");

   property p_no_pending;
      @(posedge clk_in) disable iff (rst_in)
      $rose(s.xfer_en) && nmi_act && $past(nmi_act) && !stop_mode_in &&
      !$past(stop_mode_in) |=> s.xfer_en;
   endproperty
   a_no_pending: assert property (p_no_pending)
      else $error("early nmi still aborted after enable");

   property p_stop_keeps;
      @(posedge clk_in) disable iff (rst_in)
      stop_mode_in && s.xfer_en && !in_write |=> s.xfer_en;
   endproperty
   a_stop_keeps: assert property (p_stop_keeps)
      else $error("enable cleared in stop mode");

   property p_stop_exit;
      @(posedge clk_in) disable iff (rst_in)
      $fell(stop_mode_in) && nmi_act && s.xfer_en && !in_write
      && !enable_set_in |=> !s.xfer_en;
   endproperty
   a_stop_exit: assert property (p_stop_exit)
      else $error("stop exit with nmi kept enable");

   property p_pause_ack;
      @(posedge clk_in) disable iff (rst_in)
      s.fsm == S_PAUSE |-> transfer_acknowledge_n_out && !rd_out;
   endproperty
   a_pause_ack: assert property (p_pause_ack)
      else $error("acknowledge active in pause");

   property p_resume;
      @(posedge clk_in) disable iff (rst_in)
      s.fsm == S_PAUSE && go |=> s.fsm == S_RD1;
   endproperty
   a_resume: assert property (p_resume)
      else $error("no restart after bus return");

   property p_split;
      @(posedge clk_in) disable iff (rst_in)
      q_write_start and s.dst16 |=> q_write_done ##1 burst_out;
   endproperty
   a_split: assert property (p_split)
      else $error("split write not a burst pair");

   property p_end_one;
      @(posedge clk_in) disable iff (rst_in)
      $fell(transfer_end_strobe_n_out) |->
      (s.burst ? $past(bus_cycle_start_n_out, 2) == 1'b0 :
      $past(bus_cycle_start_n_out) == 1'b0) ##1 transfer_end_strobe_n_out;
   endproperty
   a_end_one: assert property (p_end_one)
      else $error("end strobe width or timing wrong");

   property p_end_burst;
      @(posedge clk_in) disable iff (rst_in)
      !transfer_end_strobe_n_out |-> wr_out && (burst_out == s.burst);
   endproperty
   a_end_burst: assert property (p_end_burst)
      else $error("end strobe in wrong write state");

   // a 16 bit read not cut by an abort reads its second half next, HALF_STEP higher
   property p_read_pair;
      @(posedge clk_in) disable iff (rst_in)
      s.fsm == S_RD1 && s.src16 && !abort_now |=>
      burst_out && rd_out && addr_out == $past(addr_out) + HALF_STEP;
   endproperty
   a_read_pair: assert property (p_read_pair)
      else $error("16 bit read not a burst pair");

   property p_pause_after_write;
      @(posedge clk_in) disable iff (rst_in)
      $rose(hold_ack_out) |-> $past(wr_out) && transfer_acknowledge_n_out;
   endproperty
   a_pause_after_write: assert property (p_pause_after_write)
      else $error("pause began outside a write end");

   property p_hold_pos;
      @(posedge clk_in) disable iff (rst_in)
      s.fsm == S_PAUSE && !load_in |=> $stable(count);
   endproperty
   a_hold_pos: assert property (p_hold_pos)
      else $error("count moved while paused");
endmodule // dma_abort_suspend_bus_sizing

// >>> core/dma_pkg.sv
package dma_pkg;
   localparam int ADDR_W = 32;
   localparam int COUNT_W = 16;
   localparam logic [31:0] WORD_STEP = 32'h0000_0004;
   localparam logic [31:0] HALF_STEP = 32'h0000_0002;
   localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
   localparam logic [31:0] DATA_RESET = 32'h0000_0000;
   localparam logic ENABLE_RESET = 1'b0;

   typedef enum logic [6:0] {
      S_IDLE  = 7'h01,
      S_RD1   = 7'h02,
      S_RD2   = 7'h04,
      S_WA    = 7'h08,
      S_WB    = 7'h10,
      S_W2    = 7'h20,
      S_PAUSE = 7'h40
   } state_t;
endpackage

// >>> core/dma_channel_state.sv
`timescale 1ns/1ps
module dma_channel_state
   import dma_pkg::*;
#(
   parameter int AW = ADDR_W,
   parameter int CW = COUNT_W
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // setup
   input wire logic load_in,
   input wire logic [AW-1:0] src_load_in,
   input wire logic [AW-1:0] dst_load_in,
   input wire logic [CW-1:0] count_load_in,
   // progress
   input wire logic advance_in,
   output logic [AW-1:0] src_out,
   output logic [AW-1:0] dst_out,
   output logic [CW-1:0] count_out
);
   if (AW < 8 || AW > 32) begin : g_bad_aw
      $error("dma_channel_state: AW out of range");
   end

   // apart from load_in, position only moves when an item has been fully written
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         src_out <= AW'(ADDR_RESET);
         dst_out <= AW'(ADDR_RESET);
         count_out <= '0;
      end else if (load_in) begin
         src_out <= src_load_in;
         dst_out <= dst_load_in;
         count_out <= count_load_in;
      end else if (advance_in) begin
         src_out <= src_out + AW'(WORD_STEP);
         dst_out <= dst_out + AW'(WORD_STEP);
         count_out <= count_out - CW'(1);
      end
   end
endmodule // dma_channel_state

// >>> sim/dma_bus_partner.sv
`timescale 1ns/1ps
module dma_bus_partner (
   // clock
   input wire logic clk_in,
   // bus from the block
   input wire logic [31:0] addr_in,
   input wire logic rd_in,
   input wire logic wr_in,
   input wire logic [31:0] wr_data_in,
   // answers
   output logic [31:0] rd_data_out,
   output logic [31:0] last_addr_out,
   output logic [31:0] last_data_out
);
   logic [31:0] idle_pat = 32'h0000_0000;
   // released bus never shows the last word
   always @(posedge clk_in) idle_pat <= ~idle_pat;
   assign rd_data_out = rd_in ? (addr_in ^ 32'h5a5a_0000) : idle_pat;
   always @(posedge clk_in) begin
      if (wr_in) begin
         last_addr_out <= addr_in;
         last_data_out <= wr_data_in;
      end
   end
endmodule // dma_bus_partner

// >>> sim/dma_abort_suspend_bus_sizing_tb_top.sv
`timescale 1ns/1ps
module dma_abort_suspend_bus_sizing_tb_top;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic enable_set_in = 1'b0;
   logic load_in = 1'b0;
   logic dma_req_in = 1'b0;
   logic nmi_n_in = 1'b1;
   logic stop_mode_in = 1'b0;
   logic bus_hold_request_in = 1'b0;
   logic refresh_req_in = 1'b0;
   logic src_bus16_in = 1'b0;
   logic dst_bus16_in = 1'b0;
   logic dst_sdram_in = 1'b0;
   logic [31:0] src_load_in = 32'h0000_0000;
   logic [31:0] dst_load_in = 32'h0000_0000;
   logic [15:0] count_load_in = 16'h0000;
   logic [31:0] rd_data_in, addr_out, wr_data_out, last_addr, last_data;
   logic [15:0] count_out;
   logic master_transfer_enable_out, rd_out, wr_out, burst_out, hold_ack_out;
   logic bus_cycle_start_n_out, transfer_acknowledge_n_out;
   logic transfer_end_strobe_n_out;
   logic strobe_burst = 1'b0;
   logic strobe_low = 1'b0;
   int n_mismatch = 0;
   int compares = 0;
   int n_strobe = 0;

   always #2.5 clk_in = ~clk_in;

   dma_abort_suspend_bus_sizing i_dma_abort_suspend_bus_sizing (.clk_in,
      .rst_in, .enable_set_in, .master_transfer_enable_out, .load_in,
      .src_load_in, .dst_load_in, .count_load_in, .count_out, .dma_req_in,
      .nmi_n_in, .stop_mode_in, .bus_hold_request_in, .refresh_req_in,
      .src_bus16_in, .dst_bus16_in, .dst_sdram_in, .rd_data_in, .addr_out,
      .wr_data_out, .rd_out, .wr_out, .burst_out, .bus_cycle_start_n_out,
      .transfer_acknowledge_n_out, .transfer_end_strobe_n_out, .hold_ack_out);

   dma_bus_partner i_dma_bus_partner (.clk_in, .addr_in(addr_out),
      .rd_in(rd_out), .wr_in(wr_out), .wr_data_in(wr_data_out),
      .rd_data_out(rd_data_in), .last_addr_out(last_addr),
      .last_data_out(last_data));

   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic test_done;
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic tick(int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask

   task automatic wait_count(logic [15:0] target);
      for (int k = 0; k < 60 && count_out !== target; k++) tick(1);
      check("count", 32'(count_out), 32'(target));
   endtask

   task automatic wait_wr;
      for (int k = 0; k < 30 && wr_out !== 1'b1; k++) tick(1);
   endtask

   task automatic pulse_enable;
      enable_set_in = 1'b1;
      tick(1);
      enable_set_in = 1'b0;
   endtask

   task automatic start(logic [15:0] cnt, logic s16, logic d16, logic sd);
      src_bus16_in = s16;
      dst_bus16_in = d16;
      dst_sdram_in = sd;
      src_load_in = 32'h0000_0100;
      dst_load_in = 32'h0000_0200;
      count_load_in = cnt;
      load_in = 1'b1;
      tick(1);
      load_in = 1'b0;
      pulse_enable();
      dma_req_in = 1'b1;
   endtask

   // sampled mid-cycle so state decode has settled
   always @(negedge clk_in) begin
      if (!rst_in && transfer_end_strobe_n_out === 1'b0) begin
         n_strobe++;
         strobe_burst = burst_out;
         check("strobe width", 32'(strobe_low), 32'h0000_0000);
      end
      strobe_low = (transfer_end_strobe_n_out === 1'b0);
      if (hold_ack_out === 1'b1)
         check("ack paused", 32'(transfer_acknowledge_n_out), 32'h1);
   end

   task automatic t_plain;
      start(16'h0002, 1'b0, 1'b0, 1'b0);
      wait_count(16'h0000);
      dma_req_in = 1'b0;
      tick(2);
      check("strobes", 32'(n_strobe), 32'h0000_0001);
      check("last dest", last_addr, 32'h0000_0204);
      check("last data", last_data, 32'h5a5a_0104);
   endtask

   task automatic t_abort;
      start(16'h0003, 1'b0, 1'b0, 1'b0);
      wait_wr();
      nmi_n_in = 1'b0;
      tick(3);
      nmi_n_in = 1'b1;
      tick(3);
      check("abort enable", 32'(master_transfer_enable_out), 32'h0);
      check("abort count", 32'(count_out), 32'h0000_0002);
      // nmi falls while disabled and is still low at re-enable: dropped
      nmi_n_in = 1'b0;
      tick(2);
      pulse_enable();
      tick(1);
      check("kept enable", 32'(master_transfer_enable_out), 32'h1);
      nmi_n_in = 1'b1;
      wait_count(16'h0000);
      check("resume enable", 32'(master_transfer_enable_out), 32'h1);
      check("resume dest", last_addr, 32'h0000_0208);
      dma_req_in = 1'b0;
   endtask

   task automatic t_stop;
      stop_mode_in = 1'b1;
      nmi_n_in = 1'b0;
      tick(3);
      check("stop enable", 32'(master_transfer_enable_out), 32'h1);
      stop_mode_in = 1'b0;
      tick(3);
      check("wake enable", 32'(master_transfer_enable_out), 32'h0);
      nmi_n_in = 1'b1;
      tick(1);
   endtask

   task automatic t_pause;
      for (int k = 0; k < 2; k++) begin
         start(16'h0002, 1'b0, 1'b0, 1'b0);
         wait_wr();
         bus_hold_request_in = (k == 0);
         refresh_req_in = (k == 1);
         for (int j = 0; j < 10 && hold_ack_out !== 1'b1; j++) tick(1);
         check("paused", {31'h0, hold_ack_out}, 32'h1);
         tick(4);
         check("pause count", 32'(count_out), 32'h0000_0001);
         bus_hold_request_in = 1'b0;
         refresh_req_in = 1'b0;
         wait_count(16'h0000);
         dma_req_in = 1'b0;
      end
   endtask

   task automatic t_sizing;
      int n0;
      logic [31:0] dest;
      for (int k = 0; k < 3; k++) begin
         n0 = n_strobe;
         dest = (k < 2) ? 32'h0000_0202 : 32'h0000_0200;
         start(16'h0001, 1'b1, k < 2, k == 1);
         wait_count(16'h0000);
         dma_req_in = 1'b0;
         tick(2);
         check("size strobes", 32'(n_strobe - n0), 32'h0000_0001);
         check("strobe burst", 32'(strobe_burst), 32'(k == 1));
         check("size dest", last_addr, dest);
      end
      check("halves", last_data, 32'h0102_0100);
   endtask

   initial begin
      tick(8);
      rst_in = 1'b0;
      check("enable reset", 32'(master_transfer_enable_out), 32'h0);
      check("count reset", 32'(count_out), 32'h0000_0000);
      t_plain();
      t_abort();
      t_stop();
      t_pause();
      t_sizing();
      test_done();
   end

   // run needs well under a thousand cycles
   initial begin
      #20000;
      n_mismatch++;
      test_done();
   end
endmodule // dma_abort_suspend_bus_sizing_tb_top
